// File: phc_holdover_cal.sv
// PLL automatic holdover, lock detect, monitors and VCO calibration sequencer
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module phc_holdover_cal
    import phc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              lock_indicator_pin,
    input  wire logic              pd_ref_event,
    input  wire logic              pd_cycle,
    input  wire logic              pd_in_window,
    input  wire logic              sel_second_reference,
    input  wire logic              first_ref_low,
    input  wire logic              second_ref_low,
    input  wire logic              vco_clk_low,
    output logic                   cp_hiz,
    output logic                   swallow_reset,
    output logic                   digital_lock_detect,
    output logic                   lock_window_low,
    output logic      [5:0]        lock_pin_sel,
    output logic                   current_source_lock_detect,
    output logic                   ref_auto_switch,
    output logic                   prefer_second_reference,
    output logic      [1:0]        ref_buf_en,
    output logic                   ref_mon_extended,
    output logic                   pin_comparator_en,
    output logic                   ext_holdover_en,
    output logic                   cal_sync,
    output logic                   cal_tune,
    output logic                   cal_loop_open,
    output logic      [2:0]        vco_div
);

    // ************************************************************
    // Register file
    // ************************************************************
    // Writes land in a buffer; the update command moves them to the active set
    logic [7:0] buf_lock_det, buf_lock_pin, buf_ref_sel, buf_hold_ctl, buf_vco_div;
    logic [7:0] lock_det, lock_pin, ref_sel, hold_ctl, vco_div_reg;
    logic       update;
    logic       cal_done;
    logic [7:0] status;

    assign update = wr && addr == A_UPDATE && wdata[UP_GO];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            buf_lock_det <= RST_LOCK_DET;
            buf_lock_pin <= RST_LOCK_PIN;
            buf_ref_sel  <= RST_REF_SEL;
            buf_hold_ctl <= RST_HOLD_CTL;
            buf_vco_div  <= RST_VCO_DIV;
        end else if (wr) begin
            case (addr)
                A_LOCK_DET: buf_lock_det <= {1'b0, wdata[6:0]};
                A_LOCK_PIN: buf_lock_pin <= {1'b0, wdata[6:0]};
                A_REF_SEL:  buf_ref_sel  <= {3'b000, wdata[4:1], 1'b0};
                A_HOLD_CTL: buf_hold_ctl <= {4'h0, wdata[3], 1'b0, wdata[1:0]};
                A_VCO_DIV:  buf_vco_div  <= {5'h00, wdata[2:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_det    <= RST_LOCK_DET;
            lock_pin    <= RST_LOCK_PIN;
            ref_sel     <= RST_REF_SEL;
            hold_ctl    <= RST_HOLD_CTL;
            vco_div_reg <= RST_VCO_DIV;
        end else if (update) begin
            lock_det    <= buf_lock_det;
            lock_pin    <= buf_lock_pin;
            ref_sel     <= buf_ref_sel;
            hold_ctl    <= buf_hold_ctl;
            vco_div_reg <= buf_vco_div;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                A_LOCK_DET: rdata <= buf_lock_det;
                A_LOCK_PIN: rdata <= buf_lock_pin;
                A_REF_SEL:  rdata <= buf_ref_sel;
                A_HOLD_CTL: rdata <= buf_hold_ctl;
                A_VCO_DIV:  rdata <= buf_vco_div;
                A_STATUS:   rdata <= status;
                default:    rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ************************************************************
    // Configuration outputs
    // ************************************************************
    assign lock_window_low            = lock_det[LK_WIN];
    assign lock_pin_sel               = lock_pin[LP_SEL +: 6];
    assign current_source_lock_detect = lock_pin[LP_SEL +: 6] == LP_CSLOCK;
    assign ref_mon_extended           = lock_pin[LP_EXT];
    assign ref_auto_switch            = ref_sel[RS_AUTO];
    assign prefer_second_reference    = ref_sel[RS_PREF];
    assign ref_buf_en                 = ref_sel[RS_BUF +: 2];
    assign pin_comparator_en          = hold_ctl[HC_CMP];
    assign ext_holdover_en            = hold_ctl[HC_EXT];
    assign vco_div                    = vco_div_reg[2:0];

    // ************************************************************
    // Digital lock detect
    // ************************************************************
    function automatic logic [7:0] lock_need(input logic [1:0] code);
        case (code)
            2'b00:   lock_need = LOCK_N0;
            2'b01:   lock_need = LOCK_N1;
            2'b10:   lock_need = LOCK_N2;
            default: lock_need = LOCK_N3;
        endcase
    endfunction : lock_need

    logic [7:0] lock_cnt;

    // One out-of-window cycle drops lock at once; lock needs a full run again
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_cnt            <= 8'h00;
            digital_lock_detect <= 1'b0;
        end else if (lock_det[LK_DIS]) begin
            lock_cnt            <= 8'h00;
            digital_lock_detect <= 1'b0;
        end else if (pd_cycle) begin
            if (!pd_in_window) begin
                lock_cnt            <= 8'h00;
                digital_lock_detect <= 1'b0;
            end else if (lock_cnt >= lock_need(lock_det[LK_CNT +: 2]) - 8'd1) begin
                digital_lock_detect <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 8'd1;
            end
        end
    end

    // ************************************************************
    // Automatic holdover
    // ************************************************************
    phc_ho_t ho_state, next_ho_state;
    logic    pin_sensed;
    logic    ref_present;
    logic    auto_ho_en;
    logic    ho_exit;

    assign pin_sensed  = hold_ctl[HC_CMP] ? lock_indicator_pin : 1'b1;
    assign ref_present = sel_second_reference ? !second_ref_low : !first_ref_low;
    assign auto_ho_en  = hold_ctl[HC_EN] && !hold_ctl[HC_EXT];
    assign ho_exit     = pd_ref_event && ref_present;

    always_comb begin
        next_ho_state = ho_state;
        case (ho_state)
            HO_WAIT: begin
                if (digital_lock_detect && pin_sensed) begin
                    next_ho_state = HO_ARMED;
                end
            end
            HO_ARMED: begin
                if (!pin_sensed) begin
                    next_ho_state = HO_HOLD;
                end
            end
            HO_HOLD: begin
                if (ho_exit) begin
                    next_ho_state = HO_WAIT;
                end
            end
            default: next_ho_state = HO_WAIT;
        endcase
        if (!auto_ho_en) begin
            next_ho_state = HO_WAIT;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ho_state <= HO_WAIT;
        end else begin
            ho_state <= next_ho_state;
        end
    end

    assign cp_hiz = ho_state == HO_HOLD;

    // Only the swallow counter is cleared; the prescaler keeps running
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            swallow_reset <= 1'b0;
        end else begin
            swallow_reset <= ho_state == HO_HOLD && ho_exit && auto_ho_en;
        end
    end

    // ************************************************************
    // Frequency monitors and status
    // ************************************************************
    always_comb begin
        status          = 8'h00;
        status[ST_LOCK] = digital_lock_detect;
        status[ST_LDS]  = pin_sensed;
        status[ST_R1LO] = first_ref_low;
        status[ST_R2LO] = second_ref_low;
        status[ST_VCLO] = vco_clk_low;
        status[ST_HOLD] = cp_hiz;
        status[ST_CAL]  = cal_done;
    end

    // ************************************************************
    // VCO calibration
    // ************************************************************
    phc_cal_t   cal_state, next_cal_state;
    logic [3:0] div_cnt;
    logic [4:0] div_n;
    logic       cal_tick;
    logic [12:0] tick_cnt;
    logic       cal_start;
    logic       cal_last;

    // Only a fresh 0 to 1 of the active calibrate bit starts a run
    assign cal_start = update && buf_lock_det[LK_CAL] && !lock_det[LK_CAL];
    assign div_n     = 5'd2 << lock_det[LK_CDIV +: 2];
    assign cal_tick  = pd_ref_event && div_cnt == 4'(div_n - 5'd1);
    assign cal_last  = cal_tick && tick_cnt == CAL_CYCLES - 13'd1;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 4'h0;
        end else if (cal_state == CA_IDLE || cal_tick) begin
            div_cnt <= 4'h0;
        end else if (pd_ref_event) begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            CA_IDLE: if (cal_start) next_cal_state = CA_SYNC;
            CA_SYNC: next_cal_state = CA_TUNE;
            CA_TUNE: if (cal_last) next_cal_state = CA_REL;
            CA_REL:  next_cal_state = CA_IDLE;
            default: next_cal_state = CA_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cal_state <= CA_IDLE;
            tick_cnt  <= 13'h0000;
        end else begin
            cal_state <= next_cal_state;
            if (cal_state != CA_TUNE) begin
                tick_cnt <= 13'h0000;
            end else if (cal_tick) begin
                tick_cnt <= tick_cnt + 13'h0001;
            end
        end
    end

    // A start cannot fall on the finishing cycle, so set and clear never meet
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cal_done <= 1'b0;
        end else if (cal_state == CA_REL) begin
            cal_done <= 1'b1;
        end else if (cal_state == CA_IDLE && cal_start) begin
            cal_done <= 1'b0;
        end
    end

    // Outputs resume when sync drops; the loop closes one cycle after
    assign cal_sync      = cal_state == CA_SYNC || cal_state == CA_TUNE;
    assign cal_tune      = cal_state == CA_TUNE;
    assign cal_loop_open = cal_state != CA_IDLE;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_cal_begin;
        cal_state == CA_IDLE && cal_start;
    endsequence

    sequence s_cal_finish;
        cal_tune && cal_last;
    endsequence

    a_hiz_on_loss: assert property (ho_state == HO_ARMED && auto_ho_en && !pin_sensed
        |=> cp_hiz) else $error("pump not tri-stated on lock loss");
    a_cmp_off_high: assert property (!hold_ctl[HC_CMP] |-> pin_sensed)
        else $error("pin not sensed high with comparator off");
    a_hiz_holds: assert property (cp_hiz && !ho_exit && auto_ho_en |=> cp_hiz)
        else $error("pump left tri-state without reference edge");
    a_swallow_exit: assert property (cp_hiz && ho_exit && auto_ho_en
        |=> swallow_reset && !cp_hiz) else $error("swallow reset missing at exit");
    a_no_reentry: assert property (ho_state == HO_WAIT
        && !(digital_lock_detect && pin_sensed) |=> !cp_hiz [*2])
        else $error("holdover re-entered before relock");
    a_hold_gated: assert property (!auto_ho_en |=> !cp_hiz)
        else $error("holdover active while disabled or external");
    a_lock_det_off: assert property (lock_det[LK_DIS] |=> !digital_lock_detect)
        else $error("lock detect active while disabled");
    a_cal_begin: assert property (s_cal_begin |=> cal_sync && !cal_done ##1 cal_tune)
        else $error("calibration did not start with sync");
    a_cal_end: assert property (s_cal_finish |=> !cal_sync && cal_loop_open ##1
        cal_done && !cal_loop_open) else $error("calibration end sequence wrong");
    a_no_auto_cal: assert property (cal_state == CA_IDLE && !cal_start |=> !cal_sync)
        else $error("calibration started without request");
    a_done_low_run: assert property (cal_tune |-> !cal_done)
        else $error("finished bit high during calibration");

endmodule : phc_holdover_cal

// File: phc_holdover_cal_tb.sv
// Self-checking bench for the holdover and calibration block
`timescale 1ns/10ps
module phc_holdover_cal_tb;
    import phc_pkg::*;
    localparam int PER     = 9;
    localparam int CAL_LEN = int'(CAL_CYCLES) * 2 * PER;
    logic              mclk, nrst, wr, rd, ref_on, in_win, pin_hi, sel2;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic              pd_ref_event, pd_cycle, pd_in_window, lock_indicator_pin;
    logic              r1lo, r2lo, vclo, cp_hiz, swallow_reset, digital_lock_detect;
    logic              lock_window_low, current_source_lock_detect, ref_auto_switch;
    logic              prefer_second_reference, ref_mon_extended, pin_comparator_en;
    logic              ext_holdover_en, cal_sync, cal_tune, cal_loop_open;
    logic [5:0]        lock_pin_sel;
    logic [1:0]        ref_buf_en;
    logic [2:0]        vco_div;
    logic [7:0]        hcfg [3] = '{8'h08, 8'h0b, 8'h01};
    int                failures, num_checks, n, k;

    phc_holdover_cal uut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .lock_indicator_pin(lock_indicator_pin),
        .pd_ref_event(pd_ref_event), .pd_cycle(pd_cycle), .pd_in_window(pd_in_window),
        .sel_second_reference(sel2), .first_ref_low(r1lo), .second_ref_low(r2lo),
        .vco_clk_low(vclo), .cp_hiz(cp_hiz), .swallow_reset(swallow_reset),
        .digital_lock_detect(digital_lock_detect), .lock_window_low(lock_window_low),
        .lock_pin_sel(lock_pin_sel), .current_source_lock_detect(current_source_lock_detect),
        .ref_auto_switch(ref_auto_switch), .prefer_second_reference(prefer_second_reference),
        .ref_buf_en(ref_buf_en), .ref_mon_extended(ref_mon_extended),
        .pin_comparator_en(pin_comparator_en), .ext_holdover_en(ext_holdover_en),
        .cal_sync(cal_sync), .cal_tune(cal_tune), .cal_loop_open(cal_loop_open),
        .vco_div(vco_div));

    phc_pll_model #(.PER(PER)) pll (.mclk(mclk), .nrst(nrst), .ref_on(ref_on),
        .in_win(in_win), .pin_hi(pin_hi), .pd_ref_event(pd_ref_event), .pd_cycle(pd_cycle),
        .pd_in_window(pd_in_window), .lock_indicator_pin(lock_indicator_pin),
        .first_ref_low(r1lo), .second_ref_low(r2lo), .vco_clk_low(vclo));

    always #5 mclk = ~mclk;

    // ************************************************************
    // Bus and checking tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        if (failures == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic hang;
        chk("wait bound", 16'h1, 16'h0);
        end_sim();
    endtask : hang

    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic upd;
        wr_reg(A_UPDATE, 8'h01);
        @(posedge mclk);
    endtask : upd

    task automatic relock;
        for (n = 0; n < 300 && digital_lock_detect !== 1'b1; n++) @(posedge mclk);
        if (n == 300) hang();
    endtask : relock

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        mclk = 0; nrst = 0; wr = 0; rd = 0; addr = '0; wdata = '0;
        ref_on = 0; in_win = 0; pin_hi = 0; sel2 = 0; failures = 0; num_checks = 0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        wr_reg(A_STATUS, 8'hff);
        wr_reg(10'h3ff, 8'hff);
        rd_reg(10'h3ff, v); chk("unmapped", v, 8'h00);
        rd_reg(A_STATUS, v); chk("status idle", v, 8'h1e);
        rd_reg(A_HOLD_CTL, v); chk("hold reset", v, 8'h00);
        wr_reg(A_LOCK_PIN, 8'h44);
        wr_reg(A_REF_SEL, 8'h16);
        wr_reg(A_HOLD_CTL, 8'h09);
        rd_reg(A_LOCK_PIN, v); chk("pin buffer", v, 8'h44);
        chk("pin before update", lock_pin_sel, 6'h00);
        upd();
        chk("pin source", lock_pin_sel, 6'h04);
        chk("current_source_lock_detect", current_source_lock_detect, 1'b1);
        chk("ref select", {ref_auto_switch, prefer_second_reference, ref_buf_en}, 4'hb);
        chk("extended", ref_mon_extended, 1'b1);
        chk("hold type", {pin_comparator_en, ext_holdover_en}, 2'b10);
        chk("window", lock_window_low, 1'b0);
        ref_on <= 1'b1;
        in_win <= 1'b1;
        k = 0;
        for (n = 0; n < 300 && digital_lock_detect !== 1'b1; n++) begin
            @(posedge mclk);
            if (pd_cycle === 1'b1) k++;
        end
        chk("lock count", k[7:0], 8'd5);
        rd_reg(A_STATUS, v); chk("status lock", v, 8'h09);
        in_win <= 1'b0;
        for (n = 0; n < 20 && digital_lock_detect !== 1'b0; n++) @(posedge mclk);
        chk("unlock", digital_lock_detect, 1'b0);
        in_win <= 1'b1;
        wr_reg(A_LOCK_DET, 8'h08);
        upd();
        repeat (20) @(posedge mclk);
        chk("detect off", digital_lock_detect, 1'b0);
        wr_reg(A_LOCK_DET, 8'h00);
        upd();
        relock();
        pin_hi <= 1'b1;
        repeat (3) @(posedge mclk);
        pin_hi <= 1'b0;
        ref_on <= 1'b0;
        for (n = 0; n < 4 && cp_hiz !== 1'b1; n++) @(posedge mclk);
        chk("hold entry", cp_hiz, 1'b1);
        repeat (20) @(posedge mclk);
        // Wrong reference selected: edges on the first must not end holdover
        sel2   <= 1'b1;
        ref_on <= 1'b1;
        k = 0;
        repeat (30) begin
            @(posedge mclk);
            if (cp_hiz !== 1'b1) k++;
        end
        chk("hold kept", k[7:0], 8'd0);
        sel2 <= 1'b0;
        for (n = 0; n < 20 && cp_hiz !== 1'b0; n++) @(posedge mclk);
        if (n == 20) hang();
        chk("swallow", swallow_reset, 1'b1);
        @(posedge mclk);
        chk("swallow width", swallow_reset, 1'b0);
        k = 0;
        repeat (40) begin
            @(posedge mclk);
            if (cp_hiz !== 1'b0) k++;
        end
        chk("no reentry", k[7:0], 8'd0);
        foreach (hcfg[i]) begin
            wr_reg(A_HOLD_CTL, hcfg[i]);
            upd();
            relock();
            pin_hi <= 1'b1;
            repeat (10) @(posedge mclk);
            pin_hi <= 1'b0;
            k = 0;
            repeat (10) begin
                @(posedge mclk);
                if (cp_hiz !== 1'b0) k++;
            end
            chk("hold gated", k[7:0], 8'd0);
        end
        // ************************************************************
        // Calibration
        // ************************************************************
        wr_reg(A_VCO_DIV, 8'h02);
        // Divide by two on a phase detector at a ninth of mclk keeps the tick slow enough
        wr_reg(A_LOCK_DET, 8'h01);
        for (k = 0; k < 2; k++) begin
            upd();
            for (n = 0; n < 4 && cal_sync !== 1'b1; n++) @(posedge mclk);
            chk("sync", {cal_sync, cal_loop_open}, 2'b11);
            chk("vco div", vco_div, 3'd2);
            rd_reg(A_STATUS, v); chk("done low", v[6], 1'b0);
            // Only the start of the repeat run is checked; a second full run is too long
            if (k == 1) break;
            for (n = 0; n < 6 && cal_tune !== 1'b1; n++) @(posedge mclk);
            for (n = 0; n < 90000 && cal_tune === 1'b1; n++) @(posedge mclk);
            chk("cal length", 16'(n >= CAL_LEN - 2 * PER && n <= CAL_LEN + 2 * PER), 1);
            chk("release", {cal_sync, cal_loop_open}, 2'b01);
            for (n = 0; n < 4 && cal_loop_open !== 1'b0; n++) @(posedge mclk);
            rd_reg(A_STATUS, v); chk("done", v[6], 1'b1);
            wr_reg(A_VCO_DIV, 8'h03);
            upd();
            repeat (5) @(posedge mclk);
            chk("no auto cal", cal_sync, 1'b0);
            wr_reg(A_VCO_DIV, 8'h02);
            wr_reg(A_LOCK_DET, 8'h00);
            upd();
            wr_reg(A_LOCK_DET, 8'h01);
        end
        end_sim();
    end
endmodule : phc_holdover_cal_tb

// File: phc_pkg.sv
// Constants, field layout and state types of the PLL holdover and VCO calibration block
package phc_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    localparam logic [9:0] A_LOCK_DET = 10'h018;
    localparam logic [9:0] A_LOCK_PIN = 10'h01a;
    localparam logic [9:0] A_REF_SEL  = 10'h01c;
    localparam logic [9:0] A_HOLD_CTL = 10'h01d;
    localparam logic [9:0] A_STATUS   = 10'h01f;
    localparam logic [9:0] A_VCO_DIV  = 10'h1e0;
    localparam logic [9:0] A_UPDATE   = 10'h232;

    localparam int LK_CAL  = 0;
    localparam int LK_CDIV = 1;
    localparam int LK_DIS  = 3;
    localparam int LK_WIN  = 4;
    localparam int LK_CNT  = 5;
    localparam int LP_SEL  = 0;
    localparam int LP_EXT  = 6;
    localparam int RS_BUF  = 1;
    localparam int RS_PREF = 3;
    localparam int RS_AUTO = 4;
    localparam int HC_EN   = 0;
    localparam int HC_EXT  = 1;
    localparam int HC_CMP  = 3;
    localparam int UP_GO   = 0;
    localparam int ST_LOCK = 0;
    localparam int ST_LDS  = 1;
    localparam int ST_R1LO = 2;
    localparam int ST_R2LO = 3;
    localparam int ST_VCLO = 4;
    localparam int ST_HOLD = 5;
    localparam int ST_CAL  = 6;

    localparam logic [7:0]  RST_LOCK_DET = 8'h00;
    localparam logic [7:0]  RST_LOCK_PIN = 8'h00;
    localparam logic [7:0]  RST_REF_SEL  = 8'h00;
    localparam logic [7:0]  RST_HOLD_CTL = 8'h00;
    localparam logic [7:0]  RST_VCO_DIV  = 8'h00;
    localparam logic [5:0]  LP_CSLOCK    = 6'h04;
    localparam logic [12:0] CAL_CYCLES   = 13'd4400;
    localparam logic [7:0]  LOCK_N0      = 8'd5;
    localparam logic [7:0]  LOCK_N1      = 8'd16;
    localparam logic [7:0]  LOCK_N2      = 8'd64;
    localparam logic [7:0]  LOCK_N3      = 8'd255;

    typedef enum logic [1:0] {HO_WAIT = 2'b00, HO_ARMED = 2'b01, HO_HOLD = 2'b11} phc_ho_t;
    typedef enum logic [1:0] {CA_IDLE = 2'b00, CA_SYNC = 2'b01, CA_TUNE = 2'b11,
                              CA_REL = 2'b10} phc_cal_t;
endpackage : phc_pkg

// File: phc_pll_model.sv
// Stand-in for the reference clock and the PLL core
`timescale 1ns/10ps
module phc_pll_model #(
    parameter int PER = 3
) (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic ref_on,
    input  wire logic in_win,
    input  wire logic pin_hi,
    output logic      pd_ref_event,
    output logic      pd_cycle,
    output logic      pd_in_window,
    output logic      lock_indicator_pin,
    output logic      first_ref_low,
    output logic      second_ref_low,
    output logic      vco_clk_low
);
    // ************************************************************
    // Phase detector events
    // ************************************************************
    int cnt;

    // No phase detector edge at all while the reference is gone
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt          <= 0;
            pd_ref_event <= 1'b0;
        end else begin
            cnt          <= (cnt == PER - 1) ? 0 : cnt + 1;
            pd_ref_event <= ref_on && (cnt == 0);
        end
    end

    assign pd_cycle = pd_ref_event;
    // Window flag is junk between comparisons so nobody leans on a stale level
    assign pd_in_window = pd_cycle ? in_win : cnt[0];
    assign lock_indicator_pin = pin_hi;
    // ************************************************************
    // Frequency monitors
    // ************************************************************
    assign first_ref_low  = ~ref_on;
    // Second reference is never fitted on this board model
    assign second_ref_low = 1'b1;
    assign vco_clk_low    = ~ref_on;
endmodule : phc_pll_model
